// ---- logic/dtcsr_pkg.sv ----
// Constants and types shared by the trigger register bank and its access path.
// Assumes a 64-bit debug width; the effective width may drop to 32 per access.
package dtcsr_pkg;
   localparam int DTC_DW = 64;
   localparam int DTC_AW = 12;
   localparam int DTC_HALF = 32;

   // Register numbers on the access path
   localparam logic [11:0] DTC_A_SUP_CTX = 12'h5a8;
   localparam logic [11:0] DTC_A_HYP_CTX = 12'h6a8;
   localparam logic [11:0] DTC_A_SEL = 12'h7a0;
   localparam logic [11:0] DTC_A_CFG = 12'h7a1;
   localparam logic [11:0] DTC_A_CMP = 12'h7a2;
   localparam logic [11:0] DTC_A_EXT = 12'h7a3;
   localparam logic [11:0] DTC_A_INFO = 12'h7a4;
   localparam logic [11:0] DTC_A_ENCTL = 12'h7a5;
   localparam logic [11:0] DTC_A_MACH_CTX = 12'h7a8;
   localparam logic [11:0] DTC_A_MS_CTX = 12'h7aa;

   // Config word layout at full and at half width
   localparam int DTC_KIND_LSB64 = 60;
   localparam int DTC_OWN_BIT64 = 59;
   localparam int DTC_DATA_W64 = 59;
   localparam int DTC_KIND_LSB32 = 28;
   localparam int DTC_OWN_BIT32 = 27;
   localparam int DTC_DATA_W32 = 27;

   typedef enum logic [3:0] {
      DTC_K_NONE = 4'h0,
      DTC_K_LEGACY = 4'h1,
      DTC_K_ADDR_DATA_MATCH = 4'h2,
      DTC_K_INSN_COUNT = 4'h3,
      DTC_K_INTERRUPT = 4'h4,
      DTC_K_EXCEPTION = 4'h5,
      DTC_K_ADDR_DATA_MATCH_NEW = 4'h6,
      DTC_K_EXT_SOURCE = 4'h7,
      DTC_K_CUSTOM0 = 4'hc,
      DTC_K_CUSTOM1 = 4'hd,
      DTC_K_CUSTOM2 = 4'he,
      DTC_K_DISABLED = 4'hf
   } dtc_kind_e;

   typedef enum logic [1:0] {
      DTC_PRIV_U = 2'h0,
      DTC_PRIV_S = 2'h1,
      DTC_PRIV_M = 2'h3
   } dtc_priv_e;

   // Capability info: one bit per kind; absent trigger shows bit 0 only
   localparam logic [15:0] DTC_INFO_DEFAULT = 16'h8048;
   localparam logic [15:0] DTC_INFO_NONE = 16'h0001;
   localparam logic [7:0] DTC_VERSION = 8'h01;
   localparam int DTC_MTE_BIT = 3;
   localparam int DTC_MPTE_BIT = 7;

   // Values after reset
   localparam logic [63:0] DTC_RST_WORD = 64'h0;
   localparam dtc_kind_e DTC_RST_KIND = DTC_K_DISABLED;
   localparam logic DTC_RST_BIT = 1'b0;

   // Access-path controller registers and fields
   localparam logic [3:0] DTC_H_CTRL = 4'h0;
   localparam logic [3:0] DTC_H_WDATA = 4'h1;
   localparam logic [3:0] DTC_H_RDATA = 4'h2;
   localparam logic [3:0] DTC_H_STAT = 4'h3;
   localparam int DTC_C_WE = 12;
   localparam int DTC_C_GO = 13;
   localparam int DTC_C_PRIV = 14;
   localparam int DTC_C_DBG = 16;
   localparam int DTC_C_X32 = 17;
   localparam int DTC_CTRL_W = 18;
   localparam int DTC_S_BUSY = 0;
   localparam int DTC_S_DONE = 1;
   localparam int DTC_S_ILL = 2;

   typedef enum logic [1:0] {
      DTC_H_IDLE = 2'b00,
      DTC_H_ISSUE = 2'b01,
      DTC_H_WAIT = 2'b11
   } dtc_hstate_e;
endpackage : dtcsr_pkg

// ---- logic/dtcsr_if.sv ----
// Register access path between the hart side and the trigger register bank.
// Both ends run on one clock; the bank answers one cycle after each request.
`timescale 1ns/10ps
interface dtcsr_if;
   logic req;
   logic we;
   logic [dtcsr_pkg::DTC_AW-1:0] addr;
   logic [dtcsr_pkg::DTC_DW-1:0] wdata;
   dtcsr_pkg::dtc_priv_e priv;
   logic dbg;
   logic xlen32;
   logic ack;
   logic illegal;
   logic [dtcsr_pkg::DTC_DW-1:0] rdata;

   modport device (
      input req, we, addr, wdata, priv, dbg, xlen32,
      output ack, illegal, rdata
   );
   modport hart (
      output req, we, addr, wdata, priv, dbg, xlen32,
      input ack, illegal, rdata
   );
endinterface : dtcsr_if

// ---- logic/dtcsr_slot.sv ----
// Storage and write legalizing for one trigger: config, compare and extra word.
// Assumes the bank has already gated the strobes and widened the write data.
`timescale 1ns/10ps
module dtcsr_slot #(
   parameter logic [15:0] KIND_MASK = dtcsr_pkg::DTC_INFO_DEFAULT
) (
   input logic clk,
   input logic rst,
   input logic wr_cfg,
   input logic wr_cmp,
   input logic wr_ext,
   input logic dbg,
   input logic [dtcsr_pkg::DTC_DW-1:0] cfg_wdata,
   input logic [dtcsr_pkg::DTC_DW-1:0] cmp_wdata,
   input logic [dtcsr_pkg::DTC_DW-1:0] ext_wdata,
   output logic [dtcsr_pkg::DTC_DW-1:0] cfg,
   output logic [dtcsr_pkg::DTC_DW-1:0] cmp,
   output logic [dtcsr_pkg::DTC_DW-1:0] ext
);
   import dtcsr_pkg::*;

   dtc_kind_e kind;
   dtc_kind_e next_kind;
   logic own;
   logic [DTC_DATA_W64-1:0] data;
   logic [DTC_DATA_W64-1:0] next_data;
   logic [3:0] wkind;

   assign wkind = cfg_wdata[DTC_KIND_LSB64 +: 4];

   always_comb begin
      if (cfg_wdata == DTC_RST_WORD) begin
         next_kind = DTC_K_DISABLED;
      end else if (KIND_MASK[wkind] && wkind != DTC_K_NONE && wkind != DTC_K_LEGACY) begin
         next_kind = dtc_kind_e'(wkind);
      end else begin
         // Unsupported or reserved kinds fall back to a disabled trigger
         next_kind = DTC_K_DISABLED;
      end
      // Disabled kind keeps nothing but the owner flag
      next_data = (next_kind == DTC_K_DISABLED) ? '0 : cfg_wdata[DTC_DATA_W64-1:0];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         kind <= DTC_RST_KIND;
         data <= '0;
      end else if (wr_cfg) begin
         kind <= next_kind;
         data <= next_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         own <= DTC_RST_BIT;
      end else if (wr_cfg && dbg) begin
         own <= cfg_wdata[DTC_OWN_BIT64];
      end
   end

   // Any compare/extra value is held as written, whatever the kind
   always_ff @(posedge clk) begin
      if (rst) begin
         cmp <= DTC_RST_WORD;
      end else if (wr_cmp) begin
         cmp <= cmp_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext <= DTC_RST_WORD;
      end else if (wr_ext) begin
         ext <= ext_wdata;
      end
   end

   assign cfg = {kind, own, data};
endmodule : dtcsr_slot

// ---- logic/dtcsr_dev.sv ----
// Debug trigger register bank: selection, per-trigger words, contexts, control.
// Assumes the hart presents one access per request and takes the answer a cycle later.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module dtcsr_dev #(
   parameter int NTRIG = 4,
   parameter logic [15:0] KIND_MASK = dtcsr_pkg::DTC_INFO_DEFAULT
) (
   input logic REF_CLK,
   input logic SRST,
   dtcsr_if.device csr,
   input logic TRAP_TO_M,
   input logic MRET,
   output logic [NTRIG*dtcsr_pkg::DTC_DW-1:0] TRIG_CFG,
   output logic [NTRIG*dtcsr_pkg::DTC_DW-1:0] TRIG_CMP,
   output logic [NTRIG*dtcsr_pkg::DTC_DW-1:0] TRIG_EXT,
   output logic TRIG_M_EN,
   output logic [dtcsr_pkg::DTC_DW-1:0] MACH_CTX,
   output logic [dtcsr_pkg::DTC_DW-1:0] SUP_CTX,
   output logic [dtcsr_pkg::DTC_DW-1:0] MS_CTX
);
   import dtcsr_pkg::*;

   localparam int IDXW = (NTRIG > 1) ? $clog2(NTRIG) : 1;

   logic [DTC_DW-1:0] tsel;
   logic [DTC_DW-1:0] mach_ctx;
   logic [DTC_DW-1:0] sup_ctx;
   logic [DTC_DW-1:0] ms_ctx;
   logic mte;
   logic mpte;
   logic [DTC_DW-1:0] cfg_arr [NTRIG];
   logic [DTC_DW-1:0] cmp_arr [NTRIG];
   logic [DTC_DW-1:0] ext_arr [NTRIG];
   logic [IDXW-1:0] idx;
   logic sel_ok;
   logic m_ok;
   logic s_ok;
   logic impl;
   logic allowed;
   logic take;
   logic wr;
   logic own_lock;
   logic tw;
   logic [15:0] info;
   logic [DTC_DW-1:0] sel_cfg;
   logic [DTC_DW-1:0] sel_cmp;
   logic [DTC_DW-1:0] sel_ext;
   logic [DTC_DW-1:0] ctl_word;
   logic [DTC_DW-1:0] rd_full;
   logic [DTC_DW-1:0] rd_val;
   logic [DTC_DW-1:0] w_cfg;
   logic [DTC_DW-1:0] w_sext;
   logic [DTC_DW-1:0] w_zext;

   assign m_ok = csr.dbg || (csr.priv == DTC_PRIV_M);
   assign s_ok = m_ok || (csr.priv == DTC_PRIV_S);

   // Indices past the last trigger expose an absent trigger
   assign sel_ok = (tsel < DTC_DW'(NTRIG));
   assign idx = tsel[IDXW-1:0];
   assign sel_cfg = sel_ok ? cfg_arr[idx] : '0;
   assign sel_cmp = sel_ok ? cmp_arr[idx] : '0;
   assign sel_ext = sel_ok ? ext_arr[idx] : '0;
   assign info = sel_ok ? KIND_MASK : DTC_INFO_NONE;

   always_comb begin
      ctl_word = '0;
      ctl_word[DTC_MTE_BIT] = mte;
      ctl_word[DTC_MPTE_BIT] = mpte;
   end

   // Half-width writes land in full-width field positions, hidden bits cleared except on compare/extra, which sign-extend
   assign w_cfg = csr.xlen32 ? {csr.wdata[DTC_KIND_LSB32 +: 4], csr.wdata[DTC_OWN_BIT32],
      {(DTC_DATA_W64-DTC_DATA_W32){1'b0}}, csr.wdata[DTC_DATA_W32-1:0]} : csr.wdata;
   assign w_sext = csr.xlen32 ? {{DTC_HALF{csr.wdata[DTC_HALF-1]}}, csr.wdata[DTC_HALF-1:0]}
      : csr.wdata;
   assign w_zext = csr.xlen32 ? {{DTC_HALF{1'b0}}, csr.wdata[DTC_HALF-1:0]} : csr.wdata;

   always_comb begin
      impl = 1'b1;
      allowed = m_ok;
      rd_full = '0;
      if (csr.addr == DTC_A_SUP_CTX) begin
         allowed = s_ok;
         rd_full = sup_ctx;
      end else if (csr.addr == DTC_A_HYP_CTX) begin
         // Alias of the machine context for hypervisor software
         allowed = s_ok;
         rd_full = mach_ctx;
      end else if (csr.addr == DTC_A_MS_CTX) begin
         allowed = s_ok;
         rd_full = ms_ctx;
      end else if (csr.addr == DTC_A_SEL) begin
         rd_full = tsel;
      end else if (csr.addr == DTC_A_CFG) begin
         rd_full = sel_cfg;
      end else if (csr.addr == DTC_A_CMP) begin
         rd_full = sel_cmp;
      end else if (csr.addr == DTC_A_EXT) begin
         rd_full = sel_ext;
      end else if (csr.addr == DTC_A_INFO) begin
         rd_full = {{DTC_HALF{1'b0}}, DTC_VERSION, 8'h00, info};
      end else if (csr.addr == DTC_A_ENCTL) begin
         rd_full = ctl_word;
      end else if (csr.addr == DTC_A_MACH_CTX) begin
         rd_full = mach_ctx;
      end else begin
         impl = 1'b0;
      end
   end

   // Read side of the width change: config fields move, others truncate
   always_comb begin
      if (!csr.xlen32) begin
         rd_val = rd_full;
      end else if (csr.addr == DTC_A_CFG) begin
         rd_val = {{DTC_HALF{1'b0}}, rd_full[DTC_KIND_LSB64 +: 4], rd_full[DTC_OWN_BIT64],
            rd_full[DTC_DATA_W32-1:0]};
      end else begin
         rd_val = {{DTC_HALF{1'b0}}, rd_full[DTC_HALF-1:0]};
      end
   end

   assign take = csr.req && impl && allowed;
   assign wr = take && csr.we;
   // Owned trigger drops non-debug writes silently, no exception
   assign own_lock = sel_cfg[DTC_OWN_BIT64] && !csr.dbg;
   assign tw = wr && sel_ok && !own_lock;

   generate
      for (genvar i = 0; i < NTRIG; i++) begin : g_slot
         logic hit;
         assign hit = tw && (idx == IDXW'(i));
         dtcsr_slot #(
            .KIND_MASK(KIND_MASK)
         ) u_slot (
            .clk(REF_CLK),
            .rst(SRST),
            .wr_cfg(hit && (csr.addr == DTC_A_CFG)),
            .wr_cmp(hit && (csr.addr == DTC_A_CMP)),
            .wr_ext(hit && (csr.addr == DTC_A_EXT)),
            .dbg(csr.dbg),
            .cfg_wdata(w_cfg),
            .cmp_wdata(w_sext),
            .ext_wdata(w_sext),
            .cfg(cfg_arr[i]),
            .cmp(cmp_arr[i]),
            .ext(ext_arr[i])
         );
         assign TRIG_CFG[i*DTC_DW +: DTC_DW] = cfg_arr[i];
         assign TRIG_CMP[i*DTC_DW +: DTC_DW] = cmp_arr[i];
         assign TRIG_EXT[i*DTC_DW +: DTC_DW] = ext_arr[i];
      end
   endgenerate

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         tsel <= DTC_RST_WORD;
      end else if (wr && (csr.addr == DTC_A_SEL)) begin
         tsel <= w_zext;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mach_ctx <= DTC_RST_WORD;
      end else if (wr && (csr.addr == DTC_A_MACH_CTX || csr.addr == DTC_A_HYP_CTX)) begin
         mach_ctx <= w_zext;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         sup_ctx <= DTC_RST_WORD;
      end else if (wr && (csr.addr == DTC_A_SUP_CTX)) begin
         sup_ctx <= w_zext;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ms_ctx <= DTC_RST_WORD;
      end else if (wr && (csr.addr == DTC_A_MS_CTX)) begin
         ms_ctx <= w_zext;
      end
   end

   // Trap entry and return beat a software write in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         mte <= DTC_RST_BIT;
         mpte <= DTC_RST_BIT;
      end else if (TRAP_TO_M) begin
         mpte <= mte;
         mte <= 1'b0;
      end else if (MRET) begin
         mte <= mpte;
      end else if (wr && (csr.addr == DTC_A_ENCTL)) begin
         mte <= csr.wdata[DTC_MTE_BIT];
         mpte <= csr.wdata[DTC_MPTE_BIT];
      end
   end

   // Answer carries the value before this access's write
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         csr.ack <= 1'b0;
         csr.illegal <= 1'b0;
         csr.rdata <= '0;
      end else begin
         csr.ack <= csr.req;
         csr.illegal <= csr.req && !take;
         csr.rdata <= take ? rd_val : '0;
      end
   end

   assign TRIG_M_EN = mte;
   assign MACH_CTX = mach_ctx;
   assign SUP_CTX = sup_ctx;
   assign MS_CTX = ms_ctx;
endmodule : dtcsr_dev

// ---- logic/dtcsr_host.sv ----
// Hart-side access controller: software queues one register access at a time.
// Assumes the bank answers one cycle after each request, never stalling.
`timescale 1ns/10ps
module dtcsr_host (
   input logic REF_CLK,
   input logic SRST,
   input logic [3:0] SW_ADDR,
   input logic [dtcsr_pkg::DTC_DW-1:0] SW_WDATA,
   input logic SW_WR,
   input logic SW_RD,
   output logic [dtcsr_pkg::DTC_DW-1:0] SW_RDATA,
   dtcsr_if.hart csr
);
   import dtcsr_pkg::*;

   dtc_hstate_e state;
   dtc_hstate_e next_state;
   logic [DTC_CTRL_W-1:0] ctrl;
   logic [DTC_DW-1:0] wdata_r;
   logic [DTC_DW-1:0] rdata_r;
   logic done;
   logic ill;
   logic idle;
   logic go;
   logic fin;
   logic stat_wr;

   assign idle = (state == DTC_H_IDLE);
   // One access in flight keeps the programmed order intact
   assign go = SW_WR && (SW_ADDR == DTC_H_CTRL) && SW_WDATA[DTC_C_GO] && idle;
   assign fin = (state == DTC_H_WAIT) && csr.ack;
   assign stat_wr = SW_WR && (SW_ADDR == DTC_H_STAT);

   always_comb begin
      next_state = state;
      case (state)
         DTC_H_IDLE: if (go) next_state = DTC_H_ISSUE;
         DTC_H_ISSUE: next_state = DTC_H_WAIT;
         DTC_H_WAIT: if (csr.ack) next_state = DTC_H_IDLE;
         default: next_state = DTC_H_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state <= DTC_H_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Setup is frozen while busy so the request stays stable
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ctrl <= '0;
         wdata_r <= DTC_RST_WORD;
      end else if (idle && SW_WR) begin
         if (SW_ADDR == DTC_H_CTRL) begin
            ctrl <= SW_WDATA[DTC_CTRL_W-1:0];
         end else if (SW_ADDR == DTC_H_WDATA) begin
            wdata_r <= SW_WDATA;
         end
      end
   end

   // Only the latest answer is kept, until the next one; a write returns the value before it
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdata_r <= DTC_RST_WORD;
      end else if (fin) begin
         rdata_r <= csr.rdata;
      end
   end

   // Sticky flags, write one to clear; a new answer beats the clear
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         done <= 1'b0;
         ill <= 1'b0;
      end else begin
         done <= fin | (done & ~(stat_wr & SW_WDATA[DTC_S_DONE]));
         ill <= (fin & csr.illegal) | (ill & ~(stat_wr & SW_WDATA[DTC_S_ILL]));
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         SW_RDATA <= '0;
      end else if (!SW_RD) begin
         SW_RDATA <= '0;
      end else if (SW_ADDR == DTC_H_CTRL) begin
         SW_RDATA <= {{(DTC_DW-DTC_CTRL_W){1'b0}}, ctrl};
      end else if (SW_ADDR == DTC_H_WDATA) begin
         SW_RDATA <= wdata_r;
      end else if (SW_ADDR == DTC_H_RDATA) begin
         SW_RDATA <= rdata_r;
      end else if (SW_ADDR == DTC_H_STAT) begin
         SW_RDATA <= {{(DTC_DW-3){1'b0}}, ill, done, !idle};
      end else begin
         SW_RDATA <= '0;
      end
   end

   assign csr.req = (state == DTC_H_ISSUE);
   assign csr.we = ctrl[DTC_C_WE];
   assign csr.addr = ctrl[DTC_AW-1:0];
   assign csr.wdata = wdata_r;
   assign csr.priv = dtc_priv_e'(ctrl[DTC_C_PRIV +: 2]);
   assign csr.dbg = ctrl[DTC_C_DBG];
   assign csr.xlen32 = ctrl[DTC_C_X32];
endmodule : dtcsr_host

// ---- sim/dtcsr_assertions.sv ----
// Checker on the access path between the hart-side controller and the trigger bank.
// Assumes one shared clock and the bank's default kind mask (kinds 3, 6 and 15).
`timescale 1ns/10ps
module dtcsr_assertions (
   input logic REF_CLK,
   input logic SRST,
   input logic req,
   input logic we,
   input logic [dtcsr_pkg::DTC_AW-1:0] addr,
   input logic [dtcsr_pkg::DTC_DW-1:0] wdata,
   input dtcsr_pkg::dtc_priv_e priv,
   input logic dbg,
   input logic xlen32,
   input logic ack,
   input logic illegal,
   input logic [dtcsr_pkg::DTC_DW-1:0] rdata
);
   import dtcsr_pkg::*;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);
   logic impl;
   logic ctx;
   assign impl = addr inside {DTC_A_SUP_CTX, DTC_A_HYP_CTX, DTC_A_SEL, DTC_A_CFG, DTC_A_CMP,
      DTC_A_EXT, DTC_A_INFO, DTC_A_ENCTL, DTC_A_MACH_CTX, DTC_A_MS_CTX};
   assign ctx = addr inside {DTC_A_SUP_CTX, DTC_A_HYP_CTX, DTC_A_MS_CTX};
   property p_answer_next;
      req |=> ack;
   endproperty
   a_answer_next: assert property (p_answer_next)
      else $error("request without answer");
   property p_answer_cause;
      ack |-> $past(req);
   endproperty
   a_answer_cause: assert property (p_answer_cause)
      else $error("answer without request");
   property p_req_single;
      req |=> !req && $stable(addr) && $stable(wdata) && $stable(we);
   endproperty
   a_req_single: assert property (p_req_single)
      else $error("request not held or repeated");
   property p_unimpl;
      req && !impl |=> illegal && rdata == '0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented register not refused");
   property p_user;
      req && !dbg && priv != DTC_PRIV_M && priv != DTC_PRIV_S |=> illegal;
   endproperty
   a_user: assert property (p_user)
      else $error("user access not refused");
   property p_mach_only;
      req && !dbg && priv == DTC_PRIV_S && impl && !ctx |=> illegal && rdata == '0;
   endproperty
   a_mach_only: assert property (p_mach_only)
      else $error("supervisor reached machine register");
   property p_granted;
      req && impl && (dbg || priv == DTC_PRIV_M) |=> ack && !illegal;
   endproperty
   a_granted: assert property (p_granted)
      else $error("privileged access refused");
   property p_sup_ctx;
      req && ctx && priv == DTC_PRIV_S |=> !illegal;
   endproperty
   a_sup_ctx: assert property (p_sup_ctx)
      else $error("supervisor context access refused");
   property p_kind_legal;
      ack && !illegal && $past(addr) == DTC_A_CFG && !$past(xlen32)
         |-> rdata[63:60] inside {4'h0, 4'h3, 4'h6, 4'hf};
   endproperty
   a_kind_legal: assert property (p_kind_legal)
      else $error("unsupported kind read back");
   property p_kind0_clear;
      ack && !illegal && $past(addr) == DTC_A_CFG && !$past(xlen32) && rdata[63:60] == 4'h0
         |-> rdata[59:0] == '0;
   endproperty
   a_kind0_clear: assert property (p_kind0_clear)
      else $error("absent trigger shows owner or data");
   property p_quiet;
      !ack |-> rdata == '0 && !illegal;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("answer lines active without answer");
   c_cfg_write: cover property (req && we && addr == DTC_A_CFG);
   c_illegal: cover property (ack && illegal);
   c_half: cover property (req && xlen32 && we);
   c_debug: cover property (req && dbg && we);
endmodule : dtcsr_assertions

// ---- sim/tb.sv ----
// Testbench: host controller and trigger bank joined by the access interface.
// Software port driven on rising edges; expectations follow the bank's rules.
`timescale 1ns/10ps
module tb;
   import dtcsr_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [63:0] sw_wdata = 64'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic trap = 1'b0;
   logic mret = 1'b0;
   logic [63:0] sw_rdata, mach_ctx, sup_ctx, ms_ctx, rd;
   logic [255:0] trig_cfg, trig_cmp, trig_ext;
   logic trig_m_en;
   logic ill;
   int failures = 0;
   int n_checks = 0;
   dtcsr_if csr_if ();
   always #12.5 clk = ~clk;
   dtcsr_host dtcsr_host_i (.REF_CLK(clk), .SRST(srst), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata),
      .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .csr(csr_if.hart));
   dtcsr_dev dtcsr_dev_i (.REF_CLK(clk), .SRST(srst), .csr(csr_if.device), .TRAP_TO_M(trap),
      .MRET(mret), .TRIG_CFG(trig_cfg), .TRIG_CMP(trig_cmp), .TRIG_EXT(trig_ext),
      .TRIG_M_EN(trig_m_en), .MACH_CTX(mach_ctx), .SUP_CTX(sup_ctx), .MS_CTX(ms_ctx));
   dtcsr_assertions dtcsr_assertions_i (.REF_CLK(clk), .SRST(srst), .req(csr_if.req),
      .we(csr_if.we), .addr(csr_if.addr), .wdata(csr_if.wdata), .priv(csr_if.priv),
      .dbg(csr_if.dbg), .xlen32(csr_if.xlen32), .ack(csr_if.ack), .illegal(csr_if.illegal),
      .rdata(csr_if.rdata));
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : chk
   // One software strobe; read data lands in the cycle after the strobe
   task automatic sw(input logic rdn, input logic [3:0] a, input logic [63:0] d,
         output logic [63:0] q);
      @(posedge clk);
      sw_wr <= !rdn;
      sw_rd <= rdn;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge clk);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      #1 q = sw_rdata;
   endtask : sw
   task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] p,
         input logic dg, input logic x, input logic [63:0] d);
      logic [63:0] s;
      int k;
      sw(1'b0, DTC_H_STAT, 64'h7, s);
      sw(1'b0, DTC_H_WDATA, d, s);
      sw(1'b0, DTC_H_CTRL, {46'h0, x, dg, p, 1'b1, w, a}, s);
      s = 64'h0;
      for (k = 0; k < 16 && s[DTC_S_DONE] !== 1'b1; k++) sw(1'b1, DTC_H_STAT, 64'h0, s);
      chk(64'(s[DTC_S_DONE]), 64'h1, "access never completed");
      ill = s[DTC_S_ILL];
      sw(1'b1, DTC_H_RDATA, 64'h0, rd);
   endtask : acc
   task automatic w(input logic [11:0] a, input logic [63:0] d);
      acc(1'b1, a, DTC_PRIV_M, 1'b0, 1'b0, d);
   endtask : w
   task automatic r(input logic [11:0] a, input logic [63:0] exp, input string msg);
      acc(1'b0, a, DTC_PRIV_M, 1'b0, 1'b0, 64'h0);
      chk(rd, exp, msg);
   endtask : r
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      r(DTC_A_CFG, 64'hf000_0000_0000_0000, "cfg after reset");
      r(DTC_A_SEL, 64'h0, "select after reset");
      r(DTC_A_INFO, 64'h0100_8048, "info kinds");
      for (int k = 0; k < 16; k++) begin
         logic [3:0] ek;
         ek = (k inside {3, 6, 15}) ? k[3:0] : 4'hf;
         w(DTC_A_CFG, 64'h0);
         w(DTC_A_CFG, {k[3:0], 60'h5});
         acc(1'b0, DTC_A_CFG, DTC_PRIV_M, 1'b0, 1'b0, 64'h0);
         chk({60'h0, rd[63:60]}, {60'h0, ek}, "kind legalizing");
      end
      w(DTC_A_CFG, 64'h0);
      w(DTC_A_CMP, 64'h1234_5678_9abc_def0);
      w(DTC_A_EXT, 64'h0fed_cba9_8765_4321);
      w(DTC_A_CFG, 64'h6200_0000_0000_0005);
      r(DTC_A_CFG, 64'h6200_0000_0000_0005, "programmed cfg");
      r(DTC_A_CMP, 64'h1234_5678_9abc_def0, "cmp kept by cfg write");
      chk(trig_cfg[127:64], 64'hf000_0000_0000_0000, "other trigger touched");
      chk(trig_ext[63:0], 64'h0fed_cba9_8765_4321, "ext word");
      // Half width: fields move, hidden high bits cleared, compare sign-extends
      acc(1'b0, DTC_A_CFG, DTC_PRIV_M, 1'b0, 1'b1, 64'h0);
      chk(rd, 64'h6000_0005, "half width cfg view");
      acc(1'b1, DTC_A_CFG, DTC_PRIV_M, 1'b0, 1'b1, 64'h6000_0007);
      r(DTC_A_CFG, 64'h6000_0000_0000_0007, "hidden bits cleared");
      acc(1'b1, DTC_A_CMP, DTC_PRIV_M, 1'b0, 1'b1, 64'h8000_0001);
      r(DTC_A_CMP, 64'hffff_ffff_8000_0001, "cmp sign extension");
      w(DTC_A_SEL, 64'h1);
      w(DTC_A_CMP, 64'h55);
      chk(trig_cmp[127:64], 64'h55, "selected trigger cmp");
      chk(trig_cmp[63:0], 64'hffff_ffff_8000_0001, "unselected cmp");
      w(DTC_A_SEL, 64'h4);
      r(DTC_A_CFG, 64'h0, "absent trigger cfg");
      r(DTC_A_INFO, 64'h0100_0001, "absent trigger info");
      w(DTC_A_SEL, 64'h0);
      acc(1'b0, 12'h7a6, DTC_PRIV_M, 1'b0, 1'b0, 64'h0);
      chk(64'(ill), 64'h1, "unimplemented register");
      acc(1'b1, DTC_A_CMP, DTC_PRIV_U, 1'b0, 1'b0, 64'h99);
      chk(64'(ill), 64'h1, "user cmp write");
      acc(1'b1, DTC_A_CMP, DTC_PRIV_S, 1'b0, 1'b0, 64'h99);
      chk(64'(ill), 64'h1, "supervisor cmp write");
      r(DTC_A_CMP, 64'hffff_ffff_8000_0001, "refused write changed cmp");
      acc(1'b1, DTC_A_SUP_CTX, DTC_PRIV_S, 1'b0, 1'b0, 64'h33);
      chk(64'(ill), 64'h0, "supervisor context refused");
      chk(sup_ctx, 64'h33, "supervisor context");
      acc(1'b1, DTC_A_CFG, DTC_PRIV_M, 1'b1, 1'b0, 64'h6800_0000_0000_0005);
      r(DTC_A_CFG, 64'h6800_0000_0000_0005, "owner set from debug");
      w(DTC_A_CMP, 64'h77);
      w(DTC_A_CFG, 64'h0);
      r(DTC_A_CMP, 64'hffff_ffff_8000_0001, "owned cmp written");
      r(DTC_A_CFG, 64'h6800_0000_0000_0005, "owned cfg written");
      acc(1'b1, DTC_A_CMP, DTC_PRIV_M, 1'b1, 1'b0, 64'h88);
      r(DTC_A_CMP, 64'h88, "debug write to owned cmp");
      acc(1'b1, DTC_A_CFG, DTC_PRIV_M, 1'b1, 1'b0, 64'h0);
      r(DTC_A_CFG, 64'hf000_0000_0000_0000, "debug disable");
      w(DTC_A_CFG, 64'h6800_0000_0000_0005);
      r(DTC_A_CFG, 64'h6000_0000_0000_0005, "owner set from machine");
      w(DTC_A_HYP_CTX, 64'h44);
      r(DTC_A_MACH_CTX, 64'h44, "context alias");
      chk(mach_ctx, 64'h44, "machine context port");
      w(DTC_A_MS_CTX, 64'h66);
      chk(ms_ctx, 64'h66, "machine supervisor context");
      w(DTC_A_ENCTL, 64'h8);
      chk(64'(trig_m_en), 64'h1, "enable set");
      @(posedge clk);
      trap <= 1'b1;
      @(posedge clk);
      trap <= 1'b0;
      r(DTC_A_ENCTL, 64'h80, "trap saves enable");
      chk(64'(trig_m_en), 64'h0, "trap clears enable");
      @(posedge clk);
      mret <= 1'b1;
      @(posedge clk);
      mret <= 1'b0;
      @(posedge clk);
      chk(64'(trig_m_en), 64'h1, "return restores enable");
      print_verdict();
   end
endmodule : tb
